// File: design/dhpm_map.svh
// register map, field positions and timing counts of the host port master
// Behaviour
// - host drives register select to pick control, address or data register
// - port runs byte-wide, all data over an 8-bit two-way bus
// - read/write select is 1 for read, 0 for write, stable whole access
// - each access is two bytes, byte ident 0 then 1
// - port holds ready low while busy; host waits for ready high
// - chip select held low, address strobe and second strobe held high
// - host sets byte-order bit so first byte is least significant
// - host loads the address register before any data transfer
// - extended-address bit reaches upper address bits and enables increment
// - single writes for control/address, streamed transfers for data
// - address written once, then a contiguous block follows
// - read data sampled in the last phase of the strobe state
// - after each word, check transaction count, repeat or go idle
`ifndef DHPM_MAP_SVH
`define DHPM_MAP_SVH
// ****************************************
// wishbone register offsets (byte addresses)
// ****************************************
`define DHPM_CTRL_OFS 4'h0
`define DHPM_STAT_OFS 4'h4
`define DHPM_IMASK_OFS 4'h8
`define DHPM_SWORD_OFS 4'hc
// ****************************************
// field positions
// ****************************************
`define DHPM_CTRL_GO_BIT 0
`define DHPM_CTRL_RD_BIT 1
`define DHPM_CTRL_SNGL_BIT 2
`define DHPM_CTRL_SEL_LO 3
`define DHPM_CTRL_CNT_LO 16
`define DHPM_ST_DONE_BIT 0
`define DHPM_ST_PINT_BIT 1
`define DHPM_ST_BUSY_BIT 8
// ****************************************
// port register select codes
// ****************************************
`define DHPM_SEL_CONTROL 2'h0
`define DHPM_SEL_DATA_INC 2'h1
`define DHPM_SEL_ADDRESS 2'h2
`define DHPM_SEL_DATA 2'h3
// ****************************************
// timing: one phase lasts one 25 ns clock, longer than any port minimum
// ****************************************
`define DHPM_READ_DELAY_NS 10
`define DHPM_CLK_NS 25
`define DHPM_READ_DELAY_CYC \
   ((`DHPM_READ_DELAY_NS + `DHPM_CLK_NS - 1) / `DHPM_CLK_NS)
// cycles before the synchronised ready can reflect the last access
`define DHPM_RDY_SETTLE_CYC 3
`endif

// File: design/dhpm_master.sv
// host-side master of the byte-wide processor host port, wishbone controlled
`timescale 1ns/100ps
`default_nettype none
`include "dhpm_map.svh"
module dhpm_master (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   // write data stream in, read data stream out
   input wire logic [15:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   // processor host port pins
   output logic [1:0] register_select_o,
   output logic read_write_select_o,
   output logic data_strobe_n_o,
   output logic byte_ident_o,
   output logic port_chip_select_n_o,
   output logic address_strobe_n_o,
   output logic second_data_strobe_n_o,
   input wire logic [7:0] port_data_bus_i,
   output logic [7:0] port_data_bus_o,
   output logic port_data_bus_oe_n_o,
   input wire logic port_ready_n_i,
   input wire logic port_interrupt_n_i
);
   dhpm_pkg::dhpm_state_t state;
   logic [1:0] rdy_sync;
   logic [1:0] int_sync;
   logic [7:0] rd_sync0;
   logic [7:0] rd_sync1;
   logic int_seen_d;
   logic is_read;
   logic is_single;
   logic [1:0] sel_reg;
   logic [15:0] count;
   logic [15:0] word;
   logic phase;
   logic [1:0] sample_dly;
   logic [1:0] status;
   logic [1:0] imask;
   logic [15:0] sword;
   logic done_pulse;
   logic pint_pulse;
   logic wb_hit;
   logic go;
   logic busy;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // ready and interrupt come from the processor clock domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdy_sync <= 2'h0;
         int_sync <= 2'h3;
         int_seen_d <= 1'b0;
      end else begin
         rdy_sync <= {rdy_sync[0], port_ready_n_i};
         int_sync <= {int_sync[0], port_interrupt_n_i};
         int_seen_d <= ~int_sync[1];
      end
   end
   // read data must settle before the sampling phase
   always_ff @(posedge clk_i) begin
      rd_sync0 <= port_data_bus_i;
      rd_sync1 <= rd_sync0;
   end
   // interrupt from processor reset or general use raises a status event
   assign pint_pulse = ~int_sync[1] & ~int_seen_d;

   // ****************************************
   // wishbone slave
   // ****************************************
   assign wb_hit = cyc_i & stb_i & ~ack_o;
   assign go = wb_hit & we_i & (adr_i == `DHPM_CTRL_OFS) & sel_i[0]
      & dat_i[`DHPM_CTRL_GO_BIT] & (state == dhpm_pkg::dhpm_idle);
   assign busy = (state != dhpm_pkg::dhpm_idle);

   // answer one cycle after the request, every address answers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= wb_hit;
         dat_o <= 32'h0;
         if (wb_hit && !we_i) begin
            unique case (adr_i)
               `DHPM_CTRL_OFS: dat_o <= {count, 11'h0, sel_reg, is_single,
                  is_read, 1'b0};
               `DHPM_STAT_OFS: dat_o <= {23'h0, busy, 6'h0, status};
               `DHPM_IMASK_OFS: dat_o <= {30'h0, imask};
               `DHPM_SWORD_OFS: dat_o <= {16'h0, sword};
               default: dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         imask <= 2'h0;
         sword <= 16'h0;
      end else if (wb_hit && we_i) begin
         if (adr_i == `DHPM_IMASK_OFS && sel_i[0]) begin
            imask <= dat_i[1:0];
         end
         if (adr_i == `DHPM_SWORD_OFS) begin
            if (sel_i[0]) begin
               sword[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
               sword[15:8] <= dat_i[15:8];
            end
         end
      end
   end

   // sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0 && done_pulse) || (i == 1 && pint_pulse)) begin
               status[i] <= 1'b1;
            end else if (wb_hit && we_i && adr_i == `DHPM_STAT_OFS
                  && sel_i[0] && dat_i[i]) begin
               status[i] <= 1'b0;
            end
         end
      end
   end
   assign irq_o = |(status & imask);

   // ****************************************
   // transfer engine
   // ****************************************
   // fixed pins: chip select low, unused strobes high
   assign port_chip_select_n_o = 1'b0;
   assign address_strobe_n_o = 1'b1;
   assign second_data_strobe_n_o = 1'b1;
   // the write-stream ready is combinational; the stream source stalls the engine
   // the first word is taken with go, so the stream must hold data before go
   assign wr_ready_o = (go & ~dat_i[`DHPM_CTRL_SNGL_BIT]
      & ~dat_i[`DHPM_CTRL_RD_BIT])
      | ((state == dhpm_pkg::dhpm_check) & ~is_read & ~is_single & phase
      & (count != 16'h1));
   assign done_pulse = (state == dhpm_pkg::dhpm_check) & phase
      & (count == 16'h1) & (is_read ? (~rd_valid_o | rd_ready_i) : 1'b1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= dhpm_pkg::dhpm_idle;
         is_read <= 1'b0;
         is_single <= 1'b0;
         sel_reg <= `DHPM_SEL_CONTROL;
         count <= 16'h0;
         word <= 16'h0;
         phase <= 1'b0;
         sample_dly <= 2'h0;
      end else begin
         unique case (state)
            dhpm_pkg::dhpm_idle: begin
               phase <= 1'b0;
               if (go) begin
                  // single writes carry control/address words, stream moves data
                  is_single <= dat_i[`DHPM_CTRL_SNGL_BIT];
                  is_read <= dat_i[`DHPM_CTRL_RD_BIT]
                     & ~dat_i[`DHPM_CTRL_SNGL_BIT];
                  sel_reg <= dat_i[`DHPM_CTRL_SEL_LO +: 2];
                  count <= (dat_i[`DHPM_CTRL_SNGL_BIT]
                     || dat_i[31:16] == 16'h0) ? 16'h1
                     : dat_i[`DHPM_CTRL_CNT_LO +: 16];
                  word <= dat_i[`DHPM_CTRL_SNGL_BIT] ? sword : wr_data_i;
                  sample_dly <= 2'(`DHPM_RDY_SETTLE_CYC);
                  state <= dhpm_pkg::dhpm_wait_rdy;
               end
            end
            dhpm_pkg::dhpm_wait_rdy: begin
               // busy shows late through the synchroniser, so let it settle
               if (sample_dly != 2'h0) begin
                  sample_dly <= sample_dly - 2'h1;
               end else if (rdy_sync[1]) begin
                  state <= dhpm_pkg::dhpm_setup;
               end
            end
            dhpm_pkg::dhpm_setup: begin
               // selects settle one phase before the strobe falls
               state <= dhpm_pkg::dhpm_strobe;
               // two extra phases cover the two-flop copy of the data bus
               sample_dly <= 2'(`DHPM_READ_DELAY_CYC + 2);
            end
            dhpm_pkg::dhpm_strobe: begin
               // read data is taken in a later phase than the strobe's
               if (sample_dly > 2'h1) begin
                  sample_dly <= sample_dly - 2'h1;
               end else begin
                  if (is_read) begin
                     if (phase) begin
                        word[15:8] <= rd_sync1;
                     end else begin
                        word[7:0] <= rd_sync1;
                     end
                  end
                  state <= dhpm_pkg::dhpm_release;
               end
            end
            dhpm_pkg::dhpm_release: begin
               // strobe rises here, closing the byte
               state <= dhpm_pkg::dhpm_check;
            end
            dhpm_pkg::dhpm_check: begin
               if (!phase) begin
                  phase <= 1'b1;
                  state <= dhpm_pkg::dhpm_setup;
               end else if (is_read ? (~rd_valid_o | rd_ready_i)
                     : (is_single | (count == 16'h1) | wr_valid_i)) begin
                  phase <= 1'b0;
                  if (count == 16'h1) begin
                     state <= dhpm_pkg::dhpm_idle;
                  end else begin
                     count <= count - 16'h1;
                     sample_dly <= 2'(`DHPM_RDY_SETTLE_CYC);
                     if (!is_read) begin
                        word <= wr_data_i;
                     end
                     state <= dhpm_pkg::dhpm_wait_rdy;
                  end
               end
            end
            default: state <= dhpm_pkg::dhpm_idle;
         endcase
      end
   end

   // read words leave through a one-word holding register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= 16'h0;
      end else if (state == dhpm_pkg::dhpm_check && phase && is_read
            && (!rd_valid_o || rd_ready_i)) begin
         rd_valid_o <= 1'b1;
         rd_data_o <= word;
      end else if (rd_ready_i) begin
         rd_valid_o <= 1'b0;
      end
   end

   // ****************************************
   // port pin drivers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_strobe_n_o <= 1'b1;
         port_data_bus_oe_n_o <= 1'b1;
         port_data_bus_o <= 8'h0;
         register_select_o <= `DHPM_SEL_CONTROL;
         read_write_select_o <= 1'b1;
         byte_ident_o <= 1'b0;
      end else begin
         // strobe low only while in the strobe phase
         data_strobe_n_o <= ~((state == dhpm_pkg::dhpm_setup)
            | ((state == dhpm_pkg::dhpm_strobe) & (sample_dly > 2'h1)));
         if (state == dhpm_pkg::dhpm_wait_rdy
               || (state == dhpm_pkg::dhpm_check && !phase)) begin
            register_select_o <= sel_reg;
            read_write_select_o <= is_read;
            byte_ident_o <= (state == dhpm_pkg::dhpm_check);
         end
         // byte-wide bus: low byte first, driven only on writes
         port_data_bus_o <= (state == dhpm_pkg::dhpm_check && !phase)
            ? word[15:8] : (state == dhpm_pkg::dhpm_wait_rdy ? word[7:0]
            : port_data_bus_o);
         port_data_bus_oe_n_o <= ~(busy & ~is_read
            & (state != dhpm_pkg::dhpm_idle)
            & !(state == dhpm_pkg::dhpm_check && phase));
      end
   end
endmodule : dhpm_master
`default_nettype wire

// File: design/dhpm_pkg.sv
// types of the host port master
package dhpm_pkg;
   typedef enum logic [2:0] {
      dhpm_idle = 3'b000,
      dhpm_setup = 3'b001,
      dhpm_strobe = 3'b010,
      dhpm_release = 3'b011,
      dhpm_check = 3'b100,
      dhpm_wait_rdy = 3'b101
   } dhpm_state_t;
endpackage : dhpm_pkg

// File: testbench/dhpm_master_properties.sv
// pin and bus checks of the host port master
`timescale 1ns/100ps
`default_nettype none
module dhpm_master_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [1:0] register_select_o,
   input wire logic read_write_select_o,
   input wire logic data_strobe_n_o,
   input wire logic byte_ident_o,
   input wire logic port_chip_select_n_o,
   input wire logic address_strobe_n_o,
   input wire logic second_data_strobe_n_o,
   input wire logic port_data_bus_oe_n_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence first_done_s;
      $rose(data_strobe_n_o) && !byte_ident_o;
   endsequence
   sequence second_go_s;
      $fell(data_strobe_n_o) && byte_ident_o;
   endsequence
   reset_idle_a: assert property ($past(rst_i) |->
      data_strobe_n_o && port_data_bus_oe_n_o) else $error("active at reset");
   fixed_pins_a: assert property (!port_chip_select_n_o &&
      address_strobe_n_o && second_data_strobe_n_o) else $error("fixed pins");
   select_hold_a: assert property (
      (!data_strobe_n_o || $rose(data_strobe_n_o)) |-> $stable(
      {register_select_o, read_write_select_o, byte_ident_o}))
      else $error("select moved");
   byte_pair_a: assert property (first_done_s |-> ##[1:8] second_go_s)
      else $error("no second byte");
   write_drive_a: assert property (!data_strobe_n_o &&
      !read_write_select_o |-> !port_data_bus_oe_n_o) else $error("bus idle");
   read_float_a: assert property (!data_strobe_n_o &&
      read_write_select_o |-> port_data_bus_oe_n_o) else $error("bus fight");
   strobe_width_a: assert property ($fell(data_strobe_n_o) |=>
      !data_strobe_n_o ##[1:4] data_strobe_n_o) else $error("strobe width");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("long ack");
endmodule : dhpm_master_chk
bind dhpm_master dhpm_master_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
   .ack_o, .register_select_o, .read_write_select_o, .data_strobe_n_o,
   .byte_ident_o, .port_chip_select_n_o, .address_strobe_n_o,
   .second_data_strobe_n_o, .port_data_bus_oe_n_o);
`default_nettype wire

// File: testbench/dhpm_port_model.sv
// behavioural model of the processor byte-wide host port
`timescale 1ns/100ps
`default_nettype none
module dhpm_port_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] register_select_i,
   input wire logic read_write_select_i,
   input wire logic data_strobe_n_i,
   input wire logic byte_ident_i,
   input wire logic [7:0] bus_i,
   input wire logic raise_int_i,
   input wire logic [1:0] busy_len_i,
   output logic [7:0] bus_o,
   output logic port_ready_n_o,
   output logic port_interrupt_n_o
);
   logic [15:0] ctrl_reg = 0, addr_reg = 0, word = 0;
   logic [15:0] mem [0:255];
   logic [1:0] sel;
   logic rd, bil;
   int busy = 0, rcnt = 0, overrun = 0;
   initial bus_o = 8'h5a;
   always @(negedge data_strobe_n_i) begin
      sel = register_select_i;
      rd = read_write_select_i;
      bil = byte_ident_i;
      if (!port_ready_n_o) overrun++;
      if (rd && !bil)
         word = sel[0] ? mem[addr_reg[7:0]] : (sel[1] ? addr_reg : ctrl_reg);
      if (rd) #10 bus_o = bil ? word[15:8] : word[7:0];
   end
   // a released bus shows the inverse, never a stale byte
   always @(posedge data_strobe_n_i) begin
      bus_o = ~bus_o;
      if (!rd && !bil) word[7:0] = bus_i;
      if (!rd && bil) word[15:8] = bus_i;
      if (!rd && bil && sel == 2'h0) ctrl_reg = word;
      if (!rd && bil && sel == 2'h2) addr_reg = word;
      if (!rd && bil && sel[0]) mem[addr_reg[7:0]] = word;
      if (bil && sel == 2'h1) addr_reg = addr_reg + 16'h1;
      if (bil) busy = busy_len_i;
   end
   always @(posedge clk_i) begin
      if (busy > 0) busy <= busy - 1;
      port_ready_n_o <= !(busy > 0);
   end
   always @(posedge clk_i) begin
      rcnt <= rst_i ? 4 : (rcnt > 0 ? rcnt - 1 : 0);
      port_interrupt_n_o <= !(raise_int_i || (rcnt > 0 && !rst_i));
   end
endmodule : dhpm_port_model
`default_nettype wire

// File: testbench/dsp_host_port_master_bench.sv
// self-checking bench of the host port master
`timescale 1ns/100ps
`default_nettype none
`include "dhpm_map.svh"
module dsp_host_port_master_bench;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, raise = 0;
   logic [3:0] adr_i = 0, sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, q;
   logic ack_o, irq_o, wr_valid_i = 0, wr_ready_o, rd_valid_o;
   logic rd_ready_i = 0, read_write_select_o, data_strobe_n_o, byte_ident_o;
   logic port_chip_select_n_o, address_strobe_n_o, second_data_strobe_n_o;
   logic port_data_bus_oe_n_o, port_ready_n_i, port_interrupt_n_i;
   logic [15:0] wr_data_i = 0, rd_data_o, lf = 16'h0052, st = 16'h0052;
   logic [1:0] register_select_o, busy_len = 0;
   logic [7:0] port_data_bus_i, port_data_bus_o, dev_bus, base;
   logic [15:0] wq[$], rq[$], exp_mem[int];
   int err_total = 0, n_tests = 0;
   always #12.5 clk_i = ~clk_i;
   assign port_data_bus_i = port_data_bus_oe_n_o ? dev_bus : port_data_bus_o;
   dhpm_master u_dhpm_master (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .wr_data_i, .wr_valid_i,
      .wr_ready_o, .rd_data_o, .rd_valid_o, .rd_ready_i, .register_select_o,
      .read_write_select_o, .data_strobe_n_o, .byte_ident_o,
      .port_chip_select_n_o, .address_strobe_n_o, .second_data_strobe_n_o,
      .port_data_bus_i, .port_data_bus_o, .port_data_bus_oe_n_o,
      .port_ready_n_i, .port_interrupt_n_i);
   dhpm_port_model u_dhpm_port_model (.clk_i, .rst_i,
      .register_select_i(register_select_o), .bus_i(port_data_bus_o),
      .read_write_select_i(read_write_select_o), .bus_o(dev_bus),
      .data_strobe_n_i(data_strobe_n_o), .byte_ident_i(byte_ident_o),
      .raise_int_i(raise), .busy_len_i(busy_len),
      .port_ready_n_o(port_ready_n_i), .port_interrupt_n_o(port_interrupt_n_i));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
   endtask : wb
   task automatic irq_is(input logic e);
      @(negedge clk_i);
      chk("irq", {31'h0, e}, {31'h0, irq_o});
   endtask : irq_is
   // start an operation, poll done, then clear it
   task automatic run(input logic [31:0] c);
      wb(1, `DHPM_CTRL_OFS, c);
      q = 0;
      for (int i = 0; i < 300 && q[0] !== 1'b1; i++) wb(0, `DHPM_STAT_OFS, 0);
      chk("status", 32'h1, q & 32'h103);
      irq_is(1);
      wb(1, `DHPM_STAT_OFS, 32'h1);
      irq_is(0);
      $display("operation %h ended", c);
   endtask : run
   task automatic single(input logic [1:0] s, input logic [15:0] v);
      wb(1, `DHPM_SWORD_OFS, {16'h0, v});
      run({16'h1, 11'h0, s, 3'b101});
   endtask : single
   always @(posedge clk_i) begin
      if (wr_valid_i && wr_ready_o === 1'b1) void'(wq.pop_front());
      wr_valid_i <= wq.size() != 0;
      wr_data_i <= wq.size() != 0 ? wq[0] : 16'h0;
      if (rd_valid_o === 1'b1 && rd_ready_i) chk("read", rq.pop_front(), rd_data_o);
      st <= lfsr(st);
      rd_ready_i <= st[0];
      busy_len <= st[2:1];
   end
   initial begin
      #500000;
      err_total++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      repeat (12) @(posedge clk_i);
      wb(0, `DHPM_STAT_OFS, 0);
      chk("status", 32'h2, q);
      wb(1, `DHPM_IMASK_OFS, 32'h2);
      irq_is(1);
      wb(1, `DHPM_STAT_OFS, 32'h2);
      irq_is(0);
      wb(1, `DHPM_IMASK_OFS, 32'h1);
      wb(0, 4'h2, 0);
      chk("unmapped", 32'h0, q);
      single(`DHPM_SEL_CONTROL, 16'h0011);
      chk("ctrl", 32'h11, {16'h0, u_dhpm_port_model.ctrl_reg});
      base = lf[7:0];
      single(`DHPM_SEL_ADDRESS, {8'h0, base});
      for (int i = 0; i < 5; i++) begin
         lf = lfsr(lf);
         wq.push_back(lf);
         exp_mem[base + i] = lf;
      end
      run({16'h5, 11'h0, `DHPM_SEL_DATA_INC, 3'b001});
      for (int i = 0; i < 5; i++)
         chk("mem", exp_mem[base + i], u_dhpm_port_model.mem[8'(base + i)]);
      single(`DHPM_SEL_ADDRESS, {8'h0, base});
      for (int i = 0; i < 5; i++) rq.push_back(exp_mem[base + i]);
      run({16'h5, 11'h0, `DHPM_SEL_DATA_INC, 3'b011});
      single(`DHPM_SEL_DATA, 16'hc3a5);
      rq.push_back(16'hc3a5);
      run({16'h0, 11'h0, `DHPM_SEL_DATA, 3'b011});
      repeat (20) @(posedge clk_i);
      chk("left", 32'h0, rq.size());
      chk("overrun", 32'h0, u_dhpm_port_model.overrun);
      raise <= 1;
      repeat (8) @(posedge clk_i);
      raise <= 0;
      wb(0, `DHPM_STAT_OFS, 0);
      chk("status", 32'h2, q);
      close_out;
   end
endmodule : dsp_host_port_master_bench
`default_nettype wire
